// ===== hdl/cfb_mem.sv
/*
  Small memory for the queue storage; read data leave from a register.
  Assumes the caller never writes and reads the same unwritten word.
*/
`timescale 1ns/1ps
module cfb_mem
    import cfb_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH_P = DEPTH,
    parameter int AW = ADDR_W
)
(
    // Clock and reset.
    input  wire logic             i_clk_sys,
    input  wire logic             i_reset_n,
    // Write side.
    input  wire logic             i_wr_en,
    input  wire logic [AW-1:0]    i_wr_addr,
    input  wire logic [WIDTH-1:0] i_wr_data,
    // Read side.
    input  wire logic             i_rd_en,
    input  wire logic [AW-1:0]    i_rd_addr,
    output logic      [WIDTH-1:0] o_rd_data
);

    logic [WIDTH-1:0] mem_q [DEPTH_P];

    // Storage carries no reset so that it maps to plain memory.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_wr_en)
        begin
            mem_q[i_wr_addr] <= i_wr_data;
        end
    end

    // Only the read register is cleared, so the output is a known zero after reset.
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_rd_data <= '0;
        end
        else if (i_rd_en)
        begin
            o_rd_data <= mem_q[i_rd_addr];
        end
    end

endmodule : cfb_mem

// ===== hdl/cfb_pkg.sv
/*
  Shared constants and carriers for the configurable queue block.
  Assumes a single 50 MHz clock and an active-low asynchronous reset.
*/
package cfb_pkg;

    // Fixed configuration of the queue.
    localparam int DATA_W      = 16;
    localparam int COUNT_W     = 3;
    localparam int DEPTH       = 4;
    localparam int MIN_DEPTH   = 4;
    localparam int FIFO_DEPTH  = 4;
    localparam int ADDR_W      = 2;

    // Flag thresholds and count and pointer values after reset.
    localparam logic [COUNT_W:0] NEAR_FULL_LVL  = 4'h3;
    localparam logic [COUNT_W:0] NEAR_EMPTY_LVL = 4'h1;
    localparam logic [COUNT_W:0] COUNT_RST      = 4'h0;
    localparam logic [ADDR_W-1:0] PTR_RST       = 2'h0;

    // Status flags travel together.
    typedef struct packed {
        logic full;
        logic near_full;
        logic empty;
        logic near_empty;
    } cfb_flags_s;

    typedef struct packed {
        logic overflow_chk;
        logic underflow_chk;
        logic show_ahead;
    } cfb_cfg_s;

endpackage : cfb_pkg

// ===== hdl/cfb_queue.sv
/*
  Single-clock queue with fill count, near flags, guards and show-ahead.
  Assumes writer and reader logic run on i_clk_sys; inputs synchronous.
*/
`timescale 1ns/1ps
// Operation
// - Data width sets both write data and read data widths.
// - Mixed-width form would set read width separately; this form is equal-width.
// - Count width sets width of the fill count output.
// - Mixed-width read count width would be separate; not used here.
// - Depth gives word count; depth below four is rejected.
// - Mode selects normal read or show-ahead presentation of next word.
// - With overflow guard on, writes while full are ignored.
// - With underflow guard on, reads while empty are ignored.
// - Empty may rise without near-empty having risen first.
// - Near-full is high when count reaches near-full threshold.
// - Near-empty is high when count is below near-empty threshold.
module cfb_queue
    import cfb_pkg::*;
(
    // Clock and reset.
    input  wire logic              i_clk_sys,
    input  wire logic              i_reset_n,
    // Options.
    input  wire cfb_cfg_s          i_cfg,
    // Write side.
    input  wire logic              i_wr_req,
    input  wire logic [DATA_W-1:0] i_wr_data,
    output logic                   o_wr_ready,
    // Read side.
    input  wire logic              i_rd_req,
    output logic      [DATA_W-1:0] o_rd_data,
    output logic                   o_rd_valid,
    // Status.
    output logic      [COUNT_W:0]  o_fill_count,
    output cfb_flags_s             o_flags
);

    // Elaboration stops on an illegal depth.
    if (DEPTH < MIN_DEPTH)
    begin : g_depth_low
        $error("queue depth below minimum");
    end
    if (DEPTH > (1 << COUNT_W))
    begin : g_depth_big
        $error("queue depth exceeds count range");
    end

    logic [ADDR_W-1:0] wr_ptr_q;
    logic [ADDR_W-1:0] rd_ptr_q;
    logic [COUNT_W:0]  count_q;
    logic [COUNT_W:0]  count_d;
    logic              wr_fire;
    logic              rd_fire;
    logic              sa_refill_q;
    logic              sa_load;
    logic              mem_rd_en;
    logic [ADDR_W-1:0] mem_rd_addr;
    logic [DATA_W-1:0] mem_q_data;
    logic              full_w;
    logic              empty_w;

    function automatic logic [ADDR_W-1:0] ptr_next(input logic [ADDR_W-1:0] p);
        ptr_next = (p == ADDR_W'(DEPTH - 1)) ? PTR_RST : p + 1'b1;
    endfunction : ptr_next

    assign full_w  = (count_q == (COUNT_W + 1)'(DEPTH));
    assign empty_w = (count_q == COUNT_RST);

    // The guards can be switched off; then a write when full overwrites
    // and a read when empty yields undefined data, as in the plain form.
    assign wr_fire = i_wr_req && !(i_cfg.overflow_chk && full_w);
    assign rd_fire = i_rd_req && !(i_cfg.underflow_chk && empty_w);

    always_comb
    begin
        count_d = count_q;
        if (wr_fire && !rd_fire)
        begin
            count_d = count_q + 1'b1;
        end
        else if (rd_fire && !wr_fire)
        begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_ptr_q <= PTR_RST;
        end
        else if (wr_fire)
        begin
            wr_ptr_q <= ptr_next(wr_ptr_q);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rd_ptr_q <= PTR_RST;
        end
        else if (rd_fire)
        begin
            rd_ptr_q <= ptr_next(rd_ptr_q);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            count_q <= COUNT_RST;
        end
        else
        begin
            count_q <= count_d;
        end
    end

    // Show-ahead prefetches the head word; it costs a bypass mux before
    // the memory address, which is what lowers the reachable clock rate.
    // A word written into an empty queue is fetched one edge later, since a
    // same-edge read returns the old contents; readers must allow for it.
    assign sa_load = i_cfg.show_ahead
                     && (sa_refill_q || (rd_fire && (count_q > (COUNT_W + 1)'(1))));
    assign mem_rd_en   = i_cfg.show_ahead ? sa_load : rd_fire;
    assign mem_rd_addr = (i_cfg.show_ahead && rd_fire) ? ptr_next(rd_ptr_q) : rd_ptr_q;

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            sa_refill_q <= 1'b0;
        end
        else
        begin
            sa_refill_q <= i_cfg.show_ahead && wr_fire && (count_d == (COUNT_W + 1)'(1));
        end
    end

    cfb_mem #(
        .WIDTH   (DATA_W),
        .DEPTH_P (FIFO_DEPTH),
        .AW      (ADDR_W)
    ) u_mem (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_wr_en   (wr_fire),
        .i_wr_addr (wr_ptr_q),
        .i_wr_data (i_wr_data),
        .i_rd_en   (mem_rd_en),
        .i_rd_addr (mem_rd_addr),
        .o_rd_data (mem_q_data)
    );

    // Width of read data equals write data in this equal-width form.
    // The memory's read register is the output stage, so a normal read
    // shows its word on the same edge that takes the request.
    assign o_rd_data = mem_q_data;

    // Status outputs are registered from the next-state count.
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_fill_count <= COUNT_RST;
            o_wr_ready   <= 1'b1;
            o_rd_valid   <= 1'b0;
            o_flags      <= '{full: 1'b0, near_full: 1'b0, empty: 1'b1, near_empty: 1'b1};
        end
        else
        begin
            o_fill_count       <= count_d;
            o_wr_ready         <= (count_d != (COUNT_W + 1)'(DEPTH));
            o_rd_valid         <= rd_fire && !i_cfg.show_ahead;
            o_flags.full       <= (count_d == (COUNT_W + 1)'(DEPTH));
            o_flags.near_full  <= (count_d >= NEAR_FULL_LVL);
            o_flags.empty      <= (count_d == COUNT_RST);
            o_flags.near_empty <= (count_d < NEAR_EMPTY_LVL);
        end
    end

    a_full_blocks: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_cfg.overflow_chk && full_w && i_wr_req && !i_rd_req) |=> $stable(count_q))
        else $error("write accepted while full");

    a_empty_blocks: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_cfg.underflow_chk && empty_w && i_rd_req) |=> $stable(rd_ptr_q))
        else $error("read accepted while empty");

    a_count_step: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_wr_req && !i_rd_req && !full_w) |=> (o_fill_count == $past(o_fill_count) + 1'b1))
        else $error("fill count did not step up");

    a_ahead_hold: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_cfg.show_ahead && !i_rd_req && !sa_refill_q) |=> $stable(o_rd_data))
        else $error("head word changed without a read");

    a_normal_hold: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (!i_cfg.show_ahead && !rd_fire) |=> $stable(o_rd_data))
        else $error("read data changed without a read");

    a_near_full: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_flags.near_full == (count_q >= NEAR_FULL_LVL))
        else $error("near full mismatch");

    a_near_empty: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_flags.near_empty == (count_q < NEAR_EMPTY_LVL))
        else $error("near empty mismatch");

    a_count_bound: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (count_q <= (COUNT_W + 1)'(DEPTH)) || !i_cfg.overflow_chk)
        else $error("count beyond depth");

    a_order_ptrs: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_cfg.overflow_chk && i_cfg.underflow_chk)
        |-> (ADDR_W'(wr_ptr_q - rd_ptr_q) == ADDR_W'(count_q)))
        else $error("pointers disagree with count");

    a_normal_read: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (!i_cfg.show_ahead && rd_fire) |=> o_rd_valid)
        else $error("normal read latency wrong");

    a_full_flag: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_flags.full == (count_q == (COUNT_W + 1)'(DEPTH)))
        else $error("full flag mismatch");

endmodule : cfb_queue

// ===== tb/cfb_agent.sv
/*
  Writer and reader agent that stands in for user logic at the queue.
  Assumes bench commands change just after the rising clock edge.
*/
`timescale 1ns/1ps
module cfb_agent
    import cfb_pkg::*;
(
    // Commands from the bench.
    input  wire logic              i_want_wr,
    input  wire logic              i_want_rd,
    input  wire logic              i_force_rd,
    input  wire logic [DATA_W-1:0] i_data,
    // Queue status.
    input  wire cfb_flags_s        i_flags,
    // Requests to the queue.
    output logic                   o_wr_req,
    output logic                   o_rd_req,
    output logic      [DATA_W-1:0] o_wr_data
);
    // Reads wait for a non-empty queue; forcing exists only to test refusal.
    assign o_rd_req  = i_want_rd && (i_force_rd || !i_flags.empty);
    assign o_wr_req  = i_want_wr;
    // Idle data is inverted so that a stale word never looks fresh.
    assign o_wr_data = i_want_wr ? i_data : ~i_data;
endmodule : cfb_agent

// ===== tb/configurable_fifo_buffer_tb.sv
/*
  Self-checking bench for the single-clock queue, random and corner traffic.
  Assumes the agent model drives the queue's request ports.
*/
`timescale 1ns/1ps
module configurable_fifo_buffer_tb;
    import cfb_pkg::*;
    logic              i_clk_sys;
    logic              i_reset_n;
    cfb_cfg_s          cfg;
    logic              want_wr, want_rd, force_rd, wr_req, rd_req, wr_ready, rd_valid;
    logic [DATA_W-1:0] data, wr_data, rd_data;
    logic [COUNT_W:0]  fill_count;
    cfb_flags_s        flags;
    logic [15:0]       q[$];
    logic              pend;
    logic              fresh;
    logic [15:0]       pend_d;
    int                errors, checks_done, i;

    cfb_agent i_agent (.i_want_wr(want_wr), .i_want_rd(want_rd), .i_force_rd(force_rd),
        .i_data(data), .i_flags(flags), .o_wr_req(wr_req), .o_rd_req(rd_req),
        .o_wr_data(wr_data));
    cfb_queue i_dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_cfg(cfg),
        .i_wr_req(wr_req), .i_wr_data(wr_data), .o_wr_ready(wr_ready), .i_rd_req(rd_req),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_fill_count(fill_count),
        .o_flags(flags));

    function automatic cfb_flags_s exp_flags(input int n);
        exp_flags = '{full: n == DEPTH, near_full: n >= NEAR_FULL_LVL, empty: n == 0,
                      near_empty: n < NEAR_EMPTY_LVL};
    endfunction : exp_flags

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask : chk

    // One cycle: drive a request, check what the previous one left behind.
    task automatic cyc(input logic w, input logic r, input logic f);
        logic [15:0] d;
        logic        wa;
        d = 16'($urandom);
        @(posedge i_clk_sys);
        want_wr  <= w;
        want_rd  <= r;
        force_rd <= f;
        data     <= d;
        #1;
        chk("fill count", 16'(q.size()), 16'(fill_count));
        chk("flags", 16'(exp_flags(q.size())), 16'(flags));
        chk("write ready", 16'(q.size() != DEPTH), 16'(wr_ready));
        chk("read valid", 16'(pend && !cfg.show_ahead), 16'(rd_valid));
        if (pend && !cfg.show_ahead)
            chk("read data", pend_d, rd_data);
        if (cfg.show_ahead && q.size() != 0 && !fresh)
            chk("ahead data", q[0], rd_data);
        wa   = w && q.size() < DEPTH;
        pend = r && q.size() != 0;
        if (pend)
            pend_d = q.pop_front();
        fresh = wa && q.size() == 0;
        if (wa)
            q.push_back(d);
    endtask : cyc

    task automatic rst(input logic sa, input logic guard);
        @(posedge i_clk_sys);
        i_reset_n <= 1'b0;
        cfg       <= '{overflow_chk: guard, underflow_chk: guard, show_ahead: sa};
        want_wr   <= 1'b0;
        want_rd   <= 1'b0;
        repeat (5) @(posedge i_clk_sys);
        #1;
        chk("reset data", 16'h0000, rd_data);
        chk("reset flags", 16'(exp_flags(0)), 16'(flags));
        q.delete();
        pend  = 1'b0;
        fresh = 1'b0;
        @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
    endtask : rst

    task automatic traffic(input int n);
        for (i = 0; i < n; i++)
            cyc(($urandom % 4) < ((i / 40) % 2 ? 1 : 3), ($urandom % 4) < ((i / 40) % 2 ? 3 : 1),
                1'b0);
    endtask : traffic

    task automatic results;
        $display("checks_done %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    initial
    begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    // A normal run needs under a thousand cycles; this is far beyond it.
    initial
    begin
        #400_000;
        errors++;
        results();
    end

    initial
    begin
        i_reset_n = 1'b0;
        cfg       = '{overflow_chk: 1'b1, underflow_chk: 1'b1, show_ahead: 1'b0};
        {want_wr, want_rd, force_rd} = 3'h0;
        data      = 16'h0000;
        pend      = 1'b0;
        fresh     = 1'b0;
        void'($urandom(32'h0000_ddb4));
        rst(1'b0, 1'b1);
        repeat (5) cyc(1'b1, 1'b0, 1'b0);
        cyc(1'b1, 1'b1, 1'b0);
        repeat (5) cyc(1'b0, 1'b1, 1'b1);
        cyc(1'b1, 1'b1, 1'b1);
        traffic(320);
        repeat (6) cyc(1'b0, 1'b1, 1'b0);
        rst(1'b1, 1'b1);
        repeat (2) cyc(1'b1, 1'b0, 1'b0);
        repeat (2)
        begin
            repeat (2) cyc(1'b0, 1'b0, 1'b0);
            chk("ahead data", q[0], rd_data);
            cyc(1'b0, 1'b1, 1'b0);
        end
        traffic(120);
        cyc(1'b0, 1'b0, 1'b0);
        rst(1'b0, 1'b0);
        repeat (4) cyc(1'b1, 1'b0, 1'b0);
        repeat (5) cyc(1'b0, 1'b1, 1'b0);
        results();
    end
endmodule : configurable_fifo_buffer_tb
